// ==== hdl/nes_pkg.sv ====
// constants, codes and types for the erase/suspend/copyback sequencer
// assumes a 100 MHz clk; times are given in ns and turned into cycles here
`default_nettype none
package nes_pkg;
  localparam int NLUN = 2;
  localparam int NPL = 4;
  localparam int CLK_NS = 10;
  // nominal times in ns (no figures printed, plain defaults)
  localparam int QUEUE_BUSY_NS = 1000;
  localparam int SHORT_REJECT_NS = 500;
  localparam int ERASE_PULSE_NS = 2000;
  localparam int BLOCK_ERASE_NS = 20000;
  localparam int PROG_NS = 3000;
  localparam int READ_NS = 1000;
  // least times, rounded up to whole cycles
  localparam int QUEUE_BUSY_CYC = (QUEUE_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_REJECT_CYC = (SHORT_REJECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLOCK_ERASE_CYC = (BLOCK_ERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_LUNSEL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_WEAR = 8'h10;
  localparam logic [7:0] REG_CFG = 8'h14;
  // status_byte bit positions, plus undefined-read flag above the byte
  localparam int SB_FAIL = 0;
  localparam int SB_SUSP = 2;
  localparam int SB_ARRAY_READY_BIT = 5;
  localparam int SB_RDY = 6;
  localparam int SB_LOCK = 7;
  localparam int SB_UNDEF = 8;
  // third address cycle layout
  localparam int A3_LUN = 4;
  // command codes
  localparam logic [7:0] C_READ = 8'h00;
  localparam logic [7:0] C_READ_GO = 8'h30;
  localparam logic [7:0] C_CB_READ_GO = 8'h35;
  localparam logic [7:0] C_PROG = 8'h80;
  localparam logic [7:0] C_CB_PROG = 8'h85;
  localparam logic [7:0] C_PROG_GO = 8'h10;
  localparam logic [7:0] C_ERASE = 8'h60;
  localparam logic [7:0] C_QUEUE_GO = 8'hD1;
  localparam logic [7:0] C_ERASE_GO = 8'hD0;
  localparam logic [7:0] C_SUSPEND = 8'h61;
  localparam logic [7:0] C_RESUME = 8'hD2;
  localparam logic [7:0] C_RST = 8'hFF;
  localparam logic [7:0] C_RST_SYNC = 8'hFC;
  localparam logic [7:0] C_RST_LUN = 8'hFA;
  localparam logic [7:0] C_STAT = 8'h70;
  localparam logic [7:0] C_STAT_EN = 8'h78;
  localparam logic [7:0] C_COL_RD = 8'h05;
  localparam logic [7:0] C_COL_WR = 8'h06;
  localparam logic [7:0] C_COL_GO = 8'hE0;
  localparam logic [7:0] C_PROG_SUSP = 8'h84;
  // reset values
  localparam logic LOCK_RST = 1'b1;
  localparam logic [15:0] WEAR_RST = 16'h0000;
  typedef enum logic [1:0] {L_IDLE, L_BUSY, L_ERASE, L_SUSP} nes_lun_e;
  typedef enum logic [1:0] {D_IDLE, D_ADDR, D_CMD2} nes_dec_e;
  typedef enum logic [3:0] {OP_NONE, OP_QUEUE, OP_ERASE, OP_SUSPEND, OP_RESUME,
    OP_RST_ALL, OP_RST_LUN, OP_PROG, OP_READ, OP_CB_READ, OP_CB_PROG, OP_OTHER} nes_op_e;
  typedef struct packed {logic lun; logic [1:0] plane; logic [7:0] blk;} nes_row_s;
  typedef struct packed {logic v; logic wr; logic [7:0] addr;} nes_aph_s;
endpackage
`default_nettype wire

// ==== hdl/nes_seq.sv ====
// erase queue, erase suspend/resume and copyback sequencing for a
// two-unit flash target, with an AHB-Lite register slave for the host
// assumes one 100 MHz clock; ready/busy is an open-drain pin outside
//
// Summary of operation
// R01: 60h, three row cycles, D1h queues a plane; unit busy for queue time.
// R02: 60h..D0h drops both ready bits, erases all queued blocks.
// R03: after queue busy ends, more queue commands or the final erase allowed.
// R04: 60h addr 60h addr D0h acts as queue then final erase.
// R05: suspend pauses only the addressed unit's erase.
// R06: suspend to a unit not erasing is ignored at once.
// R07: erase completes an erase pulse before suspending.
// R08: resume continues erase and adds one wear cycle.
// R09: 61h plus three row cycles; outcome shown once ready rises.
// R10: suspend flag and fail encode passed, failed, suspended.
// R11: fail and suspend flags hold from ready rise to next fall.
// R12: D2h resumes every suspended unit of the target.
// R13: any reset to a suspended unit cancels erase, clears status.
// R14: erase same block resumes, other block restarts, other unit untouched.
// R15: multi-plane erase over a single suspended block starts fresh.
// R16: erase subset of suspended set resumes all; new block starts fresh.
// R17: program to suspended block rejected after short busy, lock bit 0.
// R18: other programs run; program suspend refused during erase suspension.
// R19: reads run, suspended block gives undefined data, suspension kept.
// R20: resume with nothing erasing or suspended gives short reject busy.
// R21: suspend to an already suspended unit is ignored.
// R22: host should space suspend commands at least 1ms apart.
// R23: copyback is 00h-35h, wait, 85h-10h, wait, then check fail.
// R24: copyback only within one plane and unit, else fails.
// R25: only status and column commands between copyback steps; reset voids.
// R26: ready/busy driven low while any unit is busy.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`default_nettype none
module nes_seq
  import nes_pkg::*;
#(
  parameter int ERS_CYC = BLOCK_ERASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // ready/busy open-drain pin
  output logic rb_o,
  output logic rb_oe
);

  nes_aph_s aph_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic rb_oe_r;
  logic rb_o_r;
  logic lunsel_r;
  logic cfg_fail_r;
  logic cmd_we;
  logic addr_we;
  logic [7:0] wbyte;
  nes_dec_e dec_r;
  logic [7:0] c1_r;
  logic [1:0] acnt_r;
  logic [7:0] blk_a_r;
  nes_op_e op_r;
  logic chain_r;
  nes_row_s row_r;
  logic cb_v_r;
  logic cb_lun_r;
  logic [1:0] cb_pl_r;
  nes_lun_e st_r [NLUN];
  nes_lun_e ret_r [NLUN];
  logic [31:0] tmr_r [NLUN];
  logic [31:0] ers_r [NLUN];
  logic [31:0] pls_r [NLUN];
  logic sreq_r [NLUN];
  logic [NPL-1:0] qm_r [NLUN];
  logic [NPL-1:0] em_r [NLUN];
  logic [7:0] qb_r [NLUN][NPL];
  logic [7:0] eb_r [NLUN][NPL];
  logic fail_r [NLUN];
  logic susp_r [NLUN];
  logic lock_r [NLUN];
  logic undef_r [NLUN];
  logic [15:0] wear_r [NLUN];
  logic rdy [NLUN];
  logic hit [NLUN];
  logic res_ok [NLUN];
  logic [NPL-1:0] nm [NLUN];
  logic [7:0] nb [NLUN][NPL];
  logic any_ers;
  logic busy_any;
  logic [31:0] rdata;

  // second command byte of a two-byte sequence
  function automatic nes_op_e go_op(input logic [7:0] c1, input logic [7:0] b);
    nes_op_e o;
    o = OP_OTHER;
    if (c1 == C_ERASE && (b == C_QUEUE_GO || b == C_ERASE)) o = OP_QUEUE;
    if (c1 == C_ERASE && b == C_ERASE_GO) o = OP_ERASE;
    if (c1 == C_PROG && b == C_PROG_GO) o = OP_PROG;
    if (c1 == C_CB_PROG && b == C_PROG_GO) o = OP_CB_PROG;
    if (c1 == C_READ && b == C_READ_GO) o = OP_READ;
    if (c1 == C_READ && b == C_CB_READ_GO) o = OP_CB_READ;
    return o;
  endfunction

  // first command byte that needs row address cycles
  function automatic logic takes_addr(input logic [7:0] b);
    return b == C_ERASE || b == C_SUSPEND || b == C_PROG || b == C_CB_PROG ||
      b == C_READ || b == C_RST_LUN;
  endfunction

  // row falls in the suspended erase set of its unit
  function automatic logic sus_hit(input int l, input nes_row_s r);
    return st_r[l] == L_SUSP && em_r[l][r.plane] && eb_r[l][r.plane] == r.blk;
  endfunction

  // ahb address phase capture; zero wait states
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aph_r <= '0;
    end else if (hready) begin
      aph_r <= '{v: hsel & htrans[1], wr: hwrite, addr: haddr[7:0]};
    end
  end

  assign cmd_we = aph_r.v & aph_r.wr & (aph_r.addr == REG_CMD);
  assign addr_we = aph_r.v & aph_r.wr & (aph_r.addr == REG_ADDR);
  assign wbyte = hwdata[7:0];

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      REG_LUNSEL: rdata[0] = lunsel_r;
      REG_CFG: rdata[0] = cfg_fail_r;
      REG_WEAR: rdata[15:0] = wear_r[lunsel_r];
      REG_STATUS: begin
        rdata[SB_FAIL] = fail_r[lunsel_r];
        rdata[SB_SUSP] = susp_r[lunsel_r];
        rdata[SB_ARRAY_READY_BIT] = rdy[lunsel_r];
        rdata[SB_RDY] = rdy[lunsel_r];
        rdata[SB_LOCK] = lock_r[lunsel_r];
        rdata[SB_UNDEF] = undef_r[lunsel_r];
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  // bus outputs; read data latched in the address phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) hrdata_r <= rdata;
    end
  end

  // software control registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lunsel_r <= 1'b0;
      cfg_fail_r <= 1'b0;
    end else if (aph_r.v && aph_r.wr) begin
      if (aph_r.addr == REG_LUNSEL) lunsel_r <= hwdata[0];
      if (aph_r.addr == REG_CFG) cfg_fail_r <= hwdata[0];
    end
  end

  // command and address cycle decoder; ops come out as one-cycle pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_r <= D_IDLE;
      c1_r <= 8'h00;
      acnt_r <= 2'h0;
      blk_a_r <= 8'h00;
      op_r <= OP_NONE;
      row_r <= '0;
      chain_r <= 1'b0;
    end else begin
      op_r <= OP_NONE;
      chain_r <= 1'b0;
      if (cmd_we && dec_r == D_CMD2) begin
        op_r <= go_op(c1_r, wbyte); // R01 R02
        dec_r <= D_IDLE;
        if (c1_r == C_ERASE && wbyte == C_ERASE) begin
          dec_r <= D_ADDR; // R04
          chain_r <= 1'b1;
          acnt_r <= 2'h0;
        end
      end else if (cmd_we) begin
        c1_r <= wbyte;
        acnt_r <= 2'h0;
        dec_r <= takes_addr(wbyte) ? D_ADDR : D_IDLE;
        case (wbyte)
          C_RESUME: op_r <= OP_RESUME;
          C_RST, C_RST_SYNC: op_r <= OP_RST_ALL;
          // status and column commands leave copyback intact
          C_STAT, C_STAT_EN, C_COL_RD, C_COL_WR, C_COL_GO: op_r <= OP_NONE; // R25
          C_PROG_SUSP: op_r <= OP_NONE; // R18
          default: op_r <= takes_addr(wbyte) ? OP_NONE : OP_OTHER;
        endcase
      end else if (addr_we && dec_r == D_ADDR) begin
        acnt_r <= acnt_r + 2'h1;
        if (acnt_r == 2'h1) blk_a_r <= wbyte;
        if (acnt_r == 2'h2) begin
          row_r <= '{lun: wbyte[A3_LUN], plane: wbyte[1:0], blk: blk_a_r};
          dec_r <= D_CMD2;
          if (c1_r == C_SUSPEND) begin
            op_r <= OP_SUSPEND; // R09
            dec_r <= D_IDLE;
          end
          if (c1_r == C_RST_LUN) begin
            op_r <= OP_RST_LUN;
            dec_r <= D_IDLE;
          end
        end
      end
    end
  end

  // copyback source tracking; any other operation voids the cache
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cb_v_r <= 1'b0;
      cb_lun_r <= 1'b0;
      cb_pl_r <= 2'h0;
    end else if (op_r == OP_CB_READ) begin
      cb_v_r <= 1'b1; // R23
      cb_lun_r <= row_r.lun;
      cb_pl_r <= row_r.plane;
    end else if (op_r != OP_NONE) begin
      cb_v_r <= 1'b0; // R25
    end
  end

  // per-unit readiness and erase-set comparison
  always_comb begin
    any_ers = 1'b0;
    busy_any = 1'b0;
    for (int l = 0; l < NLUN; l++) begin
      rdy[l] = st_r[l] == L_IDLE || st_r[l] == L_SUSP;
      hit[l] = row_r.lun == 1'(l);
      any_ers = any_ers | st_r[l] == L_ERASE | st_r[l] == L_SUSP;
      busy_any = busy_any | !rdy[l];
      res_ok[l] = st_r[l] == L_SUSP;
      for (int p = 0; p < NPL; p++) begin
        nm[l][p] = qm_r[l][p] | (row_r.plane == 2'(p));
        nb[l][p] = (row_r.plane == 2'(p)) ? row_r.blk : qb_r[l][p];
        // resume only if every named block is already in the suspended set
        if (nm[l][p] && !(em_r[l][p] && eb_r[l][p] == nb[l][p])) res_ok[l] = 1'b0; // R15 R16
      end
    end
  end

  // unit engines: busy timers, erase progress, suspension and status
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int l = 0; l < NLUN; l++) begin
        st_r[l] <= L_IDLE;
        ret_r[l] <= L_IDLE;
        tmr_r[l] <= 32'h0000_0000;
        ers_r[l] <= 32'h0000_0000;
        pls_r[l] <= 32'h0000_0000;
        sreq_r[l] <= 1'b0;
        qm_r[l] <= '0;
        em_r[l] <= '0;
        fail_r[l] <= 1'b0;
        susp_r[l] <= 1'b0;
        lock_r[l] <= LOCK_RST;
        undef_r[l] <= 1'b0;
        wear_r[l] <= WEAR_RST;
        for (int p = 0; p < NPL; p++) begin
          qb_r[l][p] <= 8'h00;
          eb_r[l][p] <= 8'h00;
        end
      end
    end else begin
      for (int l = 0; l < NLUN; l++) begin
        case (st_r[l])
          L_BUSY: begin
            tmr_r[l] <= tmr_r[l] - 32'h1;
            if (tmr_r[l] == 32'h0) st_r[l] <= ret_r[l]; // R03
          end
          L_ERASE: begin
            ers_r[l] <= ers_r[l] + 32'h1;
            pls_r[l] <= (pls_r[l] == 32'(ERASE_PULSE_CYC - 1)) ? 32'h0 : pls_r[l] + 32'h1;
            if (ers_r[l] == 32'(ERS_CYC - 1)) begin
              st_r[l] <= L_IDLE;
              fail_r[l] <= cfg_fail_r; // R10
              em_r[l] <= '0;
              sreq_r[l] <= 1'b0;
            end else if (sreq_r[l] && pls_r[l] == 32'(ERASE_PULSE_CYC - 1)) begin
              st_r[l] <= L_SUSP; // R07
              susp_r[l] <= 1'b1; // R10
              fail_r[l] <= 1'b0;
              sreq_r[l] <= 1'b0;
            end
          end
          default: ;
        endcase
        // host operations; busy units only take suspend and reset
        case (op_r)
          OP_QUEUE: if (hit[l] && rdy[l]) begin
            qm_r[l][row_r.plane] <= 1'b1; // R01
            qb_r[l][row_r.plane] <= row_r.blk;
            // chained 60h-60h skips the busy so the closing D0h is taken
            if (!chain_r) begin
              st_r[l] <= L_BUSY; // R26 R04
              ret_r[l] <= st_r[l];
              tmr_r[l] <= 32'(QUEUE_BUSY_CYC - 1);
            end
          end
          OP_ERASE: if (hit[l] && rdy[l]) begin
            st_r[l] <= L_ERASE; // R02 R14
            qm_r[l] <= '0;
            susp_r[l] <= 1'b0;
            fail_r[l] <= 1'b0;
            lock_r[l] <= 1'b1;
            wear_r[l] <= wear_r[l] + 16'h0001; // R08
            if (!res_ok[l]) begin
              em_r[l] <= nm[l]; // R15 R16
              eb_r[l] <= nb[l];
              ers_r[l] <= 32'h0;
              pls_r[l] <= 32'h0;
            end
          end
          OP_SUSPEND: if (hit[l] && st_r[l] == L_ERASE) sreq_r[l] <= 1'b1; // R05 R06 R21
          OP_RESUME: begin
            if (st_r[l] == L_SUSP) begin
              st_r[l] <= L_ERASE; // R12
              susp_r[l] <= 1'b0;
              wear_r[l] <= wear_r[l] + 16'h0001; // R08
            end else if (!any_ers && st_r[l] == L_IDLE) begin
              st_r[l] <= L_BUSY; // R20
              ret_r[l] <= L_IDLE;
              tmr_r[l] <= 32'(SHORT_REJECT_CYC - 1);
            end
          end
          OP_RST_ALL, OP_RST_LUN: if (op_r == OP_RST_ALL || hit[l]) begin
            st_r[l] <= L_IDLE; // R13
            em_r[l] <= '0;
            qm_r[l] <= '0;
            sreq_r[l] <= 1'b0;
            fail_r[l] <= 1'b0;
            susp_r[l] <= 1'b0;
            lock_r[l] <= LOCK_RST;
            undef_r[l] <= 1'b0;
          end
          OP_PROG, OP_CB_PROG: if (hit[l] && rdy[l]) begin
            st_r[l] <= L_BUSY;
            ret_r[l] <= st_r[l]; // R18
            tmr_r[l] <= 32'(PROG_CYC - 1);
            fail_r[l] <= 1'b0;
            lock_r[l] <= 1'b1;
            if (sus_hit(l, row_r)) begin
              tmr_r[l] <= 32'(SHORT_REJECT_CYC - 1); // R17
              lock_r[l] <= 1'b0;
            end else if (op_r == OP_CB_PROG &&
                !(cb_v_r && cb_lun_r == row_r.lun && cb_pl_r == row_r.plane)) begin
              tmr_r[l] <= 32'(SHORT_REJECT_CYC - 1); // R24
              fail_r[l] <= 1'b1;
            end else begin
              fail_r[l] <= cfg_fail_r; // R23
            end
          end
          OP_READ, OP_CB_READ: if (hit[l] && rdy[l]) begin
            st_r[l] <= L_BUSY;
            ret_r[l] <= st_r[l]; // R19
            tmr_r[l] <= 32'(READ_CYC - 1);
            undef_r[l] <= sus_hit(l, row_r);
          end
          default: ;
        endcase
      end
    end
  end

  // ready/busy pin: open drain, pulled low while any unit is busy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_oe_r <= 1'b0;
      rb_o_r <= 1'b0;
    end else begin
      rb_oe_r <= busy_any; // R26
      rb_o_r <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign rb_o = rb_o_r;
  assign rb_oe = rb_oe_r;

  // checks on unit 0
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rop0;
  assign rop0 = op_r == OP_RST_ALL || (op_r == OP_RST_LUN && !row_r.lun);
  sequence s_queue0;
    op_r == OP_QUEUE && !chain_r && !row_r.lun && st_r[0] == L_IDLE;
  endsequence
  sequence s_reject0;
    op_r == OP_RESUME && !any_ers && st_r[0] == L_IDLE;
  endsequence
  chk_queue_busy: assert property (s_queue0 |=> (st_r[0] == L_BUSY)[*8]) // R01
    else $error("queue did not hold unit busy");
  chk_erase_start: assert property (op_r == OP_ERASE && !row_r.lun && st_r[0] == L_IDLE
    |=> st_r[0] == L_ERASE && !rdy[0]) // R02
    else $error("final erase did not start");
  chk_susp_idle: assert property (op_r == OP_SUSPEND && !row_r.lun && st_r[0] == L_IDLE
    |=> st_r[0] == L_IDLE && !sreq_r[0]) // R06
    else $error("suspend to idle unit not ignored");
  chk_susp_again: assert property (op_r == OP_SUSPEND && st_r[0] == L_SUSP && !rop0
    |=> st_r[0] == L_SUSP) // R21
    else $error("repeated suspend disturbed suspension");
  chk_susp_pulse: assert property (st_r[0] == L_ERASE && pls_r[0] != 32'(ERASE_PULSE_CYC - 1)
    |=> st_r[0] != L_SUSP) // R07
    else $error("suspended mid pulse");
  chk_susp_code: assert property (st_r[0] == L_SUSP |-> susp_r[0] && !fail_r[0]) // R10
    else $error("suspended status code wrong");
  chk_status_hold: assert property (rdy[0] && !rop0
    |=> !rdy[0] || ($stable(fail_r[0]) && $stable(susp_r[0]))) // R11
    else $error("status changed while ready");
  chk_resume_wear: assert property (op_r == OP_RESUME && st_r[0] == L_SUSP
    |=> st_r[0] == L_ERASE && wear_r[0] == $past(wear_r[0]) + 16'h0001) // R08
    else $error("resume not counted");
  chk_reset_cancel: assert property (rop0 && st_r[0] == L_SUSP
    |=> st_r[0] == L_IDLE && !susp_r[0]) // R13
    else $error("reset left erase suspended");
  chk_prog_lock: assert property (op_r == OP_PROG && !row_r.lun && sus_hit(0, row_r)
    |=> st_r[0] == L_BUSY && !lock_r[0] && ret_r[0] == L_SUSP) // R17
    else $error("program to suspended block not rejected");
  chk_reject_done: assert property (s_reject0
    |=> st_r[0] == L_BUSY ##[1:60] st_r[0] == L_IDLE) // R20
    else $error("reject busy too long");
  chk_rb_busy: assert property (!rdy[0] |=> rb_oe) // R26
    else $error("ready/busy not driven");

endmodule
`default_nettype wire

// ==== tb/nes_rb_pull.sv ====
// host side of the ready/busy pin: open-drain wire with a pull-up
// assumes the sequencer only ever pulls the line low
`default_nettype none
module nes_rb_pull (
  // pin drive from the sequencer
  input wire logic rb_o,
  input wire logic rb_oe,
  // level the host controller sees
  output logic rb_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line floats up, never to the last driven value
  assign rb_lvl = rb_oe ? rb_o : 1'b1;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the erase queue, suspend and copyback sequencer
// assumes zero-wait register slave and a shortened erase time
`default_nettype none
module tb
  import nes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, rb_o, rb_oe, rb_lvl;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, w0;
  logic [7:0] rc;
  int err_count = 0;
  int num_checks = 0;
  nes_seq #(.ERS_CYC(400)) nes_seq_i (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rb_o(rb_o), .rb_oe(rb_oe));
  nes_rb_pull nes_rb_pull_i (.rb_o(rb_o), .rb_oe(rb_oe), .rb_lvl(rb_lvl));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // wait for hready; sampled mid-cycle so no race with the edge
  task automatic hs;
    logic ok;
    do begin
      @(negedge clk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    hs;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hs;
  endtask
  task automatic c(input logic [7:0] b);
    bus(1'b1, REG_CMD, {24'h0, b});
  endtask
  // page, block, then unit in bit 4 and plane in [1:0]
  task automatic op(input logic [7:0] c1, input logic [7:0] blk, input logic l,
                    input logic [1:0] p, input logic [7:0] c2);
    c(c1);
    bus(1'b1, REG_ADDR, 32'h0);
    bus(1'b1, REG_ADDR, {24'h0, blk});
    bus(1'b1, REG_ADDR, {27'h0, l, 2'b00, p});
    if (c2 !== 8'h00) c(c2);
  endtask
  task automatic st(input string n, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(n, e, rd & m);
  endtask
  // unit state lands two edges after the command's data phase
  task automatic bst;
    repeat (2) @(posedge clk);
    st("busy", 32'h60, 32'h0);
  endtask
  // bounded poll of the ready bit
  task automatic wrdy;
    int i;
    i = 0;
    // let the last command reach the unit before polling
    repeat (2) @(posedge clk);
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      i++;
    end while (rd[SB_RDY] !== 1'b1 && i < 3000);
    if (i >= 3000) chk("ready wait", 32'h1, 32'h0);
  endtask
  task automatic pin(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("rb wire", {31'h0, e}, {31'h0, rb_lvl});
    @(posedge clk);
  endtask
  // each erase is suspended at most once, so suspends never crowd it
  task automatic susp(input logic [7:0] blk);
    op(C_ERASE, blk, 1'b0, 2'd0, C_ERASE_GO);
    op(C_SUSPEND, blk, 1'b0, 2'd0, 8'h00);
    wrdy;
  endtask
  // watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    complete_run;
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    st("reset status", 32'h1E5, 32'h0E0);
    bus(1'b0, REG_WEAR, 32'h0);
    chk("wear", 32'h0, rd & 32'hFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    pin(1'b1);
    op(C_ERASE, 8'h01, 1'b0, 2'd0, C_QUEUE_GO);
    bst;
    pin(1'b0);
    wrdy;
    op(C_ERASE, 8'h02, 1'b0, 2'd1, C_ERASE_GO);
    bst;
    wrdy;
    st("erase done", 32'h1C5, 32'h0C0);
    op(C_ERASE, 8'h03, 1'b0, 2'd0, 8'h00);
    op(C_ERASE, 8'h04, 1'b0, 2'd1, C_ERASE_GO);
    bst;
    wrdy;
    st("double erase", 32'h1C5, 32'h0C0);
    bus(1'b0, REG_WEAR, 32'h0);
    w0 = rd & 32'hFFFF;
    chk("wear chained", 32'h2, w0);
    op(C_ERASE, 8'h05, 1'b0, 2'd2, C_ERASE_GO);
    op(C_SUSPEND, 8'h05, 1'b0, 2'd2, 8'h00);
    pin(1'b0);
    wrdy;
    st("suspended", 32'h1C5, 32'h0C4);
    op(C_SUSPEND, 8'h05, 1'b0, 2'd2, 8'h00);
    pin(1'b1);
    st("still suspended", 32'h05, 32'h04);
    op(C_PROG, 8'h05, 1'b0, 2'd2, C_PROG_GO);
    bst;
    wrdy;
    st("prog reject", 32'h85, 32'h04);
    op(C_PROG, 8'h09, 1'b0, 2'd2, C_PROG_GO);
    bst;
    wrdy;
    st("other prog", 32'h05, 32'h04);
    op(C_READ, 8'h05, 1'b0, 2'd2, C_READ_GO);
    bst;
    wrdy;
    st("undef read", 32'h105, 32'h104);
    c(C_RESUME);
    bst;
    wrdy;
    st("resumed", 32'h05, 32'h00);
    bus(1'b0, REG_WEAR, 32'h0);
    chk("wear", w0 + 32'h2, rd & 32'hFFFF);
    op(C_ERASE, 8'h06, 1'b0, 2'd0, C_ERASE_GO);
    op(C_ERASE, 8'h07, 1'b1, 2'd0, C_ERASE_GO);
    op(C_SUSPEND, 8'h06, 1'b0, 2'd0, 8'h00);
    wrdy;
    bus(1'b1, REG_LUNSEL, 32'h1);
    st("other unit", 32'h45, 32'h00);
    wrdy;
    bus(1'b1, REG_LUNSEL, 32'h0);
    st("kept", 32'h05, 32'h04);
    for (int k = 0; k < 3; k++) begin
      rc = (k == 0) ? C_RST : (k == 1) ? C_RST_SYNC : C_RST_LUN;
      susp(8'h08);
      if (k == 2) op(rc, 8'h08, 1'b0, 2'd0, 8'h00);
      else c(rc);
      repeat (2) @(posedge clk);
      st("reset cancels", 32'h05, 32'h00);
    end
    c(C_RESUME);
    pin(1'b0);
    wrdy;
    op(C_SUSPEND, 8'h01, 1'b0, 2'd0, 8'h00);
    pin(1'b1);
    bus(1'b1, REG_CFG, 32'h1);
    op(C_ERASE, 8'h02, 1'b0, 2'd0, C_ERASE_GO);
    wrdy;
    st("erase fail", 32'h05, 32'h01);
    bus(1'b1, REG_CFG, 32'h0);
    op(C_READ, 8'h0A, 1'b0, 2'd3, C_CB_READ_GO);
    wrdy;
    c(C_STAT);
    op(C_CB_PROG, 8'h0B, 1'b0, 2'd3, C_PROG_GO);
    bst;
    wrdy;
    st("copyback", 32'h01, 32'h00);
    op(C_READ, 8'h0A, 1'b0, 2'd3, C_CB_READ_GO);
    wrdy;
    op(C_CB_PROG, 8'h0B, 1'b0, 2'd2, C_PROG_GO);
    wrdy;
    st("cross plane", 32'h01, 32'h01);
    op(C_READ, 8'h0A, 1'b0, 2'd3, C_CB_READ_GO);
    wrdy;
    c(C_RST);
    op(C_CB_PROG, 8'h0B, 1'b0, 2'd3, C_PROG_GO);
    wrdy;
    st("voided cache", 32'h01, 32'h01);
    complete_run;
  end
endmodule
`default_nettype wire
